/* storage_power_cmds.sv */
// Command interpreter for multiple-mode, service and power commands.
`timescale 1ns/1ps
`default_nettype none
`include "storage_power_defs.svh"

module storage_power_cmds
    import storage_power_pkg::*;
#(
    parameter int SLEEP_TO_CYCLES = `SLEEP_TO_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        standby_expired,
    output logic             interrupt_request_line,
    output logic             standby_timer_en,
    output logic      [7:0]  standby_period_code,
    output logic      [1:0]  power_state,
    output logic             multi_enable,
    output logic      [7:0]  multi_count
);

    // *****************************************************************
    // Bus decode
    // *****************************************************************

    // Returns true when the word address matches the given offset.
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction

    // Opcode class helpers shared by dispatch and the sleep test.
    function automatic logic is_sleep(input logic [7:0] op);
        is_sleep = (op == `OP_SLEEP_A) || (op == `OP_SLEEP_B);
    endfunction

    function automatic logic is_standby(input logic [7:0] op);
        is_standby = (op == `OP_STANDBY_A) || (op == `OP_STANDBY_B) ||
                     (op == `OP_INSTANT_A) || (op == `OP_INSTANT_B);
    endfunction

    localparam int BUSY_CYCLES = `BUSY_CYC;

    logic        access;
    logic        wr_en;
    logic        rd_en;
    logic        mapped;
    cmd_state_t  state_reg;
    power_state_t pwr_reg;
    logic [7:0]  op_reg;
    logic [7:0]  seccnt_reg;
    logic [7:0]  feature_reg;
    logic [7:0]  error_reg;
    logic [7:0]  ctrl_reg;
    status_t     status_reg;
    logic        keep_reg;
    logic        irq_reg;
    logic        sleep_pend_reg;
    logic [3:0]  busy_cnt_reg;
    logic [31:0] sleep_cnt_reg;
    logic [8:0]  ident_idx_reg;
    logic        srst_req;
    logic        cmd_wr;
    logic        status_rd;
    logic        asleep;

    assign access  = psel && penable;
    assign wr_en   = access && pwrite;
    assign rd_en   = access && !pwrite;
    assign pready  = 1'b1;
    assign asleep  = (pwr_reg == PWR_SLEEP);
    assign mapped  = hit(paddr, `OFS_CMD) || hit(paddr, `OFS_SECCNT) ||
                     hit(paddr, `OFS_FEATURE) || hit(paddr, `OFS_STATUS) ||
                     hit(paddr, `OFS_ERROR) || hit(paddr, `OFS_MULTI) ||
                     hit(paddr, `OFS_POWER) || hit(paddr, `OFS_CTRL) ||
                     hit(paddr, `OFS_IDENT);
    // The host may not touch command registers in sleep, so such
    // accesses are refused rather than silently corrupting state.
    assign pslverr = access && (!mapped ||
                     (asleep && !hit(paddr, `OFS_CTRL)));
    assign srst_req  = wr_en && hit(paddr, `OFS_CTRL) &&
                       pwdata[`CTL_SRST];
    assign cmd_wr    = wr_en && !pslverr && hit(paddr, `OFS_CMD) &&
                       !status_reg.busy;
    assign status_rd = rd_en && !pslverr && hit(paddr, `OFS_STATUS);

    // Read mux; unused bits read as zero.
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en && !pslverr) begin
            if (hit(paddr, `OFS_CMD)) begin
                prdata[7:0] = op_reg;
            end else if (hit(paddr, `OFS_SECCNT)) begin
                prdata[7:0] = seccnt_reg;
            end else if (hit(paddr, `OFS_FEATURE)) begin
                prdata[7:0] = feature_reg;
            end else if (hit(paddr, `OFS_STATUS)) begin
                prdata[7:0] = status_reg;
            end else if (hit(paddr, `OFS_ERROR)) begin
                prdata[7:0] = error_reg;
            end else if (hit(paddr, `OFS_MULTI)) begin
                prdata[8:0] = {multi_enable, multi_count};
            end else if (hit(paddr, `OFS_POWER)) begin
                prdata[10:0] = {standby_timer_en, standby_period_code,
                                pwr_reg};
            end else if (hit(paddr, `OFS_CTRL)) begin
                prdata[7:0] = ctrl_reg;
            end else if (hit(paddr, `OFS_IDENT)) begin
                // Word 47 low byte reports the block size; all other
                // words are unimplemented and read zero.
                if (ident_idx_reg == 9'd47) begin
                    prdata[15:0] = {8'h00, `MAX_BLOCK};
                end
            end
        end
    end

    // *****************************************************************
    // Host-written registers
    // *****************************************************************

    // Sector count and feature registers; software reset preserves them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seccnt_reg  <= 8'h00;
            feature_reg <= 8'h00;
        end else if (wr_en && !pslverr) begin
            if (hit(paddr, `OFS_SECCNT)) begin
                seccnt_reg <= pwdata[7:0];
            end
            if (hit(paddr, `OFS_FEATURE)) begin
                feature_reg <= pwdata[7:0];
            end
        end
    end

    // Control: capability straps and the service bit. The service bit
    // may be set by software; the device clears it during service.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTL_RESET;
        end else if (wr_en && hit(paddr, `OFS_CTRL)) begin
            ctrl_reg <= {pwdata[7:1], 1'b0};
        end else if (state_reg == ST_BUSY && op_reg == `OP_SERVICE) begin
            ctrl_reg[`CTL_SERVICE] <= 1'b0;
        end
    end

    // *****************************************************************
    // Command sequencer
    // *****************************************************************

    // Opcode latch, busy counter and state. Busy rises on the command
    // write and is held a fixed time so the host always observes it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg     <= ST_IDLE;
            op_reg        <= 8'h00;
            busy_cnt_reg  <= 4'h0;
            ident_idx_reg <= 9'd0;
        end else if (srst_req) begin
            state_reg     <= ST_IDLE;
            busy_cnt_reg  <= 4'h0;
            ident_idx_reg <= 9'd0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // Packet identify is taken even when not ready.
                    if (cmd_wr) begin
                        op_reg       <= pwdata[7:0];
                        state_reg    <= ST_BUSY;
                        busy_cnt_reg <= 4'(BUSY_CYCLES);
                    end
                end
                ST_BUSY: begin
                    if (busy_cnt_reg > 4'h1) begin
                        busy_cnt_reg <= busy_cnt_reg - 4'h1;
                    end else if (op_reg == `OP_PKT_IDENT) begin
                        state_reg     <= ST_IDENT;
                        ident_idx_reg <= 9'd0;
                    end else begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_IDENT: begin
                    // Each identify register read advances one word.
                    if (rd_en && hit(paddr, `OFS_IDENT)) begin
                        if (ident_idx_reg == `IDENT_WORDS - 9'd1) begin
                            state_reg <= ST_DONE;
                        end
                        ident_idx_reg <= ident_idx_reg + 9'd1;
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Status byte. Busy tracks the sequencer; the error bit reports an
    // abort. Service leaves the overlapped command's status untouched.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 8'h40;
            error_reg  <= 8'h00;
        end else if (srst_req) begin
            status_reg <= 8'h40;
            error_reg  <= 8'h00;
        end else begin
            status_reg.busy  <= (state_reg == ST_BUSY) ||
                                (cmd_wr && state_reg == ST_IDLE);
            status_reg.drq   <= (state_reg == ST_IDENT);
            status_reg.ready <= 1'b1;
            if (state_reg == ST_BUSY && busy_cnt_reg <= 4'h1) begin
                if (op_reg == `OP_SERVICE) begin
                    // Overlapped status is kept; nothing aborted.
                    status_reg.err <= status_reg.err;
                end else if (((is_sleep(op_reg) || is_standby(op_reg)) &&
                              !ctrl_reg[`CTL_PM_SUP]) ||
                             (op_reg == `OP_SET_MULTI &&
                              (!ctrl_reg[`CTL_MULTI_SUP] ||
                               seccnt_reg > `MAX_BLOCK))) begin
                    status_reg.err <= 1'b1;
                    error_reg      <= 8'h04;
                end else begin
                    status_reg.err <= 1'b0;
                    error_reg      <= 8'h00;
                end
            end
        end
    end

    // *****************************************************************
    // Multiple mode
    // *****************************************************************

    // Revert setting: hard reset restores reverting to defaults.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keep_reg <= 1'b0;
        end else if (state_reg == ST_DONE && op_reg == `OP_SET_FEAT) begin
            if (feature_reg == `SUB_KEEP_SET) begin
                keep_reg <= 1'b1;
            end else if (feature_reg == `SUB_REVERT) begin
                keep_reg <= 1'b0;
            end
        end
    end

    // Block count and enable. Counts 1..max are accepted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            multi_enable <= 1'b0;
            multi_count  <= 8'h00;
        end else if (srst_req && !keep_reg) begin
            multi_enable <= 1'b0;
            multi_count  <= 8'h00;
        end else if (state_reg == ST_BUSY && busy_cnt_reg <= 4'h1 &&
                     op_reg == `OP_SET_MULTI) begin
            if (!ctrl_reg[`CTL_MULTI_SUP] || seccnt_reg > `MAX_BLOCK ||
                seccnt_reg == 8'h00) begin
                multi_enable <= 1'b0;
            end else begin
                multi_enable <= 1'b1;
                multi_count  <= seccnt_reg;
            end
        end
    end

    // *****************************************************************
    // Power management
    // *****************************************************************

    // Interrupt raised after busy clears; a status read clears it,
    // and the set on completion wins over a same-cycle read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else if (state_reg == ST_DONE) begin
            irq_reg <= 1'b1;
        end else if (status_rd || srst_req ||
                     sleep_cnt_reg >= 32'(SLEEP_TO_CYCLES)) begin
            irq_reg <= 1'b0;
        end
    end
    assign interrupt_request_line = irq_reg;

    // Sleep pending and its timeout counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_pend_reg <= 1'b0;
            sleep_cnt_reg  <= 32'h0000_0000;
        end else if (srst_req || asleep) begin
            sleep_pend_reg <= 1'b0;
            sleep_cnt_reg  <= 32'h0000_0000;
        end else if (state_reg == ST_DONE && is_sleep(op_reg) &&
                     !status_reg.err) begin
            sleep_pend_reg <= 1'b1;
            sleep_cnt_reg  <= 32'h0000_0000;
        end else if (sleep_pend_reg) begin
            sleep_cnt_reg <= sleep_cnt_reg + 32'h0000_0001;
        end
    end

    // Power state; sleep is left only by reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_reg <= PWR_ACTIVE;
        end else if (srst_req) begin
            pwr_reg <= PWR_ACTIVE;
        end else if (asleep) begin
            pwr_reg <= PWR_SLEEP;
        end else if (sleep_pend_reg && (status_rd ||
                     sleep_cnt_reg >= 32'(SLEEP_TO_CYCLES))) begin
            pwr_reg <= PWR_SLEEP;
        end else if (state_reg == ST_BUSY && busy_cnt_reg <= 4'h1 &&
                     is_standby(op_reg) && ctrl_reg[`CTL_PM_SUP]) begin
            pwr_reg <= PWR_STANDBY;
        end else if (standby_expired && standby_timer_en) begin
            pwr_reg <= PWR_STANDBY;
        end else if (cmd_wr) begin
            pwr_reg <= PWR_ACTIVE;
        end
    end
    assign power_state = pwr_reg;

    // Standby timer setup; only the two timed standby opcodes program.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_timer_en    <= 1'b0;
            standby_period_code <= 8'h00;
        end else if (state_reg == ST_DONE && ctrl_reg[`CTL_PM_SUP] &&
                     (op_reg == `OP_STANDBY_A ||
                      op_reg == `OP_STANDBY_B)) begin
            standby_timer_en    <= (seccnt_reg != 8'h00);
            standby_period_code <= seccnt_reg;
        end
    end

endmodule // storage_power_cmds

`default_nettype wire

/* storage_power_defs.svh */
// Offsets, field positions, reset values, opcodes and timing counts.
`ifndef STORAGE_POWER_DEFS_SVH
`define STORAGE_POWER_DEFS_SVH

// APB register byte offsets.
`define OFS_CMD        12'h000
`define OFS_SECCNT     12'h004
`define OFS_FEATURE    12'h008
`define OFS_STATUS     12'h00c
`define OFS_ERROR      12'h010
`define OFS_MULTI      12'h014
`define OFS_POWER      12'h018
`define OFS_CTRL       12'h01c
`define OFS_IDENT      12'h020

// Opcodes.
`define OP_SET_MULTI   8'hc6
`define OP_SERVICE     8'ha2
`define OP_SLEEP_A     8'h99
`define OP_SLEEP_B     8'he6
`define OP_STANDBY_A   8'h96
`define OP_STANDBY_B   8'he2
`define OP_INSTANT_A   8'h94
`define OP_INSTANT_B   8'he0
`define OP_PKT_IDENT   8'ha1
`define OP_SET_FEAT    8'hef
`define SUB_KEEP_SET   8'h66
`define SUB_REVERT     8'hcc

// Status and error register bit positions.
`define ST_ERR         0
`define ST_DRQ         3
`define ST_READY       6
`define ST_BUSY        7
`define ERR_ABORT      2

// Control register bits.
`define CTL_SRST       0
`define CTL_PM_SUP     1
`define CTL_MULTI_SUP  2
`define CTL_OVERLAP    3
`define CTL_SERVICE    4
`define CTL_RESET      8'h06

// Largest supported block count (identify word 47 low byte).
`define MAX_BLOCK      8'h10

// Identify response length in 16-bit words.
`define IDENT_WORDS    9'd256

// Busy hold time and sleep auto-entry timeout.
`define BUSY_NS        20
`define BUSY_CYC       (((`BUSY_NS) + 4) / 5)
`define SLEEP_TO_SEC   2
`define SLEEP_TO_CYC   (`SLEEP_TO_SEC * 200000000)

`endif

/* storage_power_pkg.sv */
// Types shared by the command interpreter.
package storage_power_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_BUSY  = 3'b001,
        ST_DONE  = 3'b010,
        ST_IDENT = 3'b011,
        ST_WAIT  = 3'b100
    } cmd_state_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE  = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_SLEEP   = 2'b10
    } power_state_t;

    // Status byte fields.
    typedef struct packed {
        logic busy;
        logic ready;
        logic df;
        logic dsc;
        logic drq;
        logic corr;
        logic idx;
        logic err;
    } status_t;

endpackage

/* standby_timer_model.sv */
// Behavioural standby timer driven by the interpreter's enable and code.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Standby timer model
// ****************************************************************
module standby_timer_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       timer_en,
    input  wire logic [7:0] period_code,
    output logic            expired
);
    logic [9:0] ticks_reg;

    // Counts only while enabled; the code is scaled down so runs stay short.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ticks_reg <= 10'h000;
        end else if (!timer_en) begin
            ticks_reg <= 10'h000;
        end else if (!expired) begin
            ticks_reg <= ticks_reg + 10'h001;
        end
    end

    // Expiry is a level that stays up until the timer is disabled.
    assign expired = timer_en &&
                     (ticks_reg >= {period_code, 2'b00});
endmodule // standby_timer_model
`default_nettype wire

/* storage_power_assertions.sv */
// Port-level checker for the command interpreter.
`timescale 1ns/1ps
`default_nettype none
`include "storage_power_defs.svh"
// ****************************************************************
// Checker
// ****************************************************************
module storage_power_checker
    import storage_power_pkg::*;
#(
    parameter int SLEEP_TO_CYCLES = 50
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        standby_expired,
    input wire logic        interrupt_request_line,
    input wire logic        standby_timer_en,
    input wire logic [7:0]  standby_period_code,
    input wire logic [1:0]  power_state,
    input wire logic        multi_enable,
    input wire logic [7:0]  multi_count
);
    logic       acc, cmd_wr, srst_wr, st_rd, asleep;
    logic [7:0] since_cmd;
    int         irq_cnt;

    // Host accesses decoded in the access phase only.
    assign acc = psel && penable && pready;
    assign cmd_wr = acc && pwrite && (paddr == `OFS_CMD);
    assign srst_wr = acc && pwrite && (paddr == `OFS_CTRL) && pwdata[0];
    assign st_rd = acc && !pwrite && (paddr == `OFS_STATUS);
    assign asleep = (power_state == PWR_SLEEP);

    // Saturates so that a long idle stretch never wraps back to zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_cmd <= 8'hff;
        end else if (cmd_wr) begin
            since_cmd <= 8'h00;
        end else if (since_cmd != 8'hff) begin
            since_cmd <= since_cmd + 8'h01;
        end
    end

    // Length of the unbroken interrupt, for the self-timed sleep entry.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_cnt <= 0;
        end else begin
            irq_cnt <= interrupt_request_line ? irq_cnt + 1 : 0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_BUSY_BEFORE_IRQ:
        assert property ($rose(interrupt_request_line) |-> since_cmd >= 8'd4)
        else $error("interrupt raised without a busy phase");
    AST_SLEEP_DROPS_IRQ:
        assert property ($rose(asleep) |-> $fell(interrupt_request_line))
        else $error("sleep entered with interrupt pending");
    AST_SLEEP_CAUSE:
        assert property ($rose(asleep) |->
            $past(st_rd) || irq_cnt >= SLEEP_TO_CYCLES - 2)
        else $error("sleep entered too early");
    AST_SLEEP_HOLDS:
        assert property (asleep && !srst_wr |=> asleep)
        else $error("sleep left without reset");
    AST_RESET_WAKES:
        assert property (srst_wr |=> !asleep)
        else $error("still asleep after software reset");
    AST_SLEEP_REFUSES:
        assert property (asleep && acc && paddr != `OFS_CTRL |-> pslverr)
        else $error("access accepted while asleep");
    AST_MULTI_RANGE:
        assert property (multi_enable |->
            multi_count inside {[8'd1:`MAX_BLOCK]})
        else $error("multi mode on with bad count");
    AST_TIMER_CODE:
        assert property (standby_timer_en |-> standby_period_code != 8'h00)
        else $error("timer enabled with zero code");
    AST_EXPIRY_IDLES:
        assert property (!interrupt_request_line && !srst_wr && standby_expired
            && standby_timer_en && power_state == PWR_ACTIVE
            |=> power_state == PWR_STANDBY)
        else $error("timer expiry ignored");
    AST_MULTI_CAUSED:
        assert property ($changed({multi_enable, multi_count}) |->
            since_cmd != 8'hff || $past(srst_wr))
        else $error("multi mode changed with no cause");

    COV_SLEEP: cover property ($rose(asleep));
    COV_MULTI_MAX: cover property (multi_enable && multi_count == `MAX_BLOCK);
    COV_TIMER: cover property ($rose(standby_timer_en));
endmodule // storage_power_checker

bind storage_power_cmds storage_power_checker #(
    .SLEEP_TO_CYCLES(SLEEP_TO_CYCLES)
) u_storage_power_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .standby_expired(standby_expired),
    .interrupt_request_line(interrupt_request_line),
    .standby_timer_en(standby_timer_en),
    .standby_period_code(standby_period_code), .power_state(power_state),
    .multi_enable(multi_enable), .multi_count(multi_count)
);
`default_nettype wire

/* tb.sv */
// Self-checking bench driving the interpreter over APB.
`timescale 1ns/1ps
`default_nettype none
`include "storage_power_defs.svh"
// ****************************************************************
// Bench
// ****************************************************************
module tb;
    import storage_power_pkg::*;
    localparam int TO = 50;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, err, expd, irq, ten, men;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0]  code, mcnt, lastc = 8'h00;
    logic [1:0]  pst;
    logic [7:0]  cnts [5] = '{8'h10, 8'h01, 8'h00, 8'h04, 8'h11};
    logic [7:0]  ops [6] = '{8'h99, 8'he6, 8'h96, 8'he2, 8'h94, 8'he0};
    int          miscompares = 0, cmp_count = 0, cyc = 0;

    always #2.5 pclk = ~pclk;

    storage_power_cmds #(.SLEEP_TO_CYCLES(TO)) u_storage_power_cmds (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .standby_expired(expd),
        .interrupt_request_line(irq), .standby_timer_en(ten),
        .standby_period_code(code), .power_state(pst),
        .multi_enable(men), .multi_count(mcnt));

    standby_timer_model u_standby_timer_model (.pclk(pclk),
        .presetn(presetn), .timer_en(ten), .period_code(code),
        .expired(expd));

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, s, e);
        end
    endtask

    // Setup, then access held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic wait_irq();
        for (int i = 0; i < 300 && irq !== 1'b1; i++) @(negedge pclk);
        chk(irq, 1'b1);
    endtask

    // Busy must show first; the closing status read clears the interrupt.
    task automatic cmd(input logic [7:0] op, input logic [31:0] st);
        apb(1'b1, `OFS_CMD, {24'h0, op});
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd[7], 1'b1);
        wait_irq();
        rd_chk(`OFS_STATUS, st);
        @(negedge pclk);
        chk(irq, 1'b0);
    endtask

    task automatic srst();
        apb(1'b1, `OFS_CTRL, 32'h07);
        repeat (4) @(posedge pclk);
    endtask

    // A hang is cut short and counted as a mismatch.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`OFS_STATUS, 32'h40);
        rd_chk(`OFS_MULTI, 32'h0);
        rd_chk(`OFS_POWER, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        chk(err, 1'b1);
        $display("test reset done");
        foreach (cnts[i]) begin
            apb(1'b1, `OFS_SECCNT, {24'h0, cnts[i]});
            cmd(`OP_SET_MULTI, {31'h20, cnts[i] > `MAX_BLOCK});
            if (cnts[i] != 0 && cnts[i] <= `MAX_BLOCK) lastc = cnts[i];
            rd_chk(`OFS_MULTI,
                   {23'h0, cnts[i] == lastc, lastc});
        end
        rd_chk(`OFS_ERROR, 32'h04);
        apb(1'b1, `OFS_SECCNT, 32'h08);
        cmd(`OP_SET_MULTI, 32'h40);
        apb(1'b1, `OFS_FEATURE, 32'h66);
        cmd(`OP_SET_FEAT, 32'h40);
        srst();
        rd_chk(`OFS_MULTI, 32'h108);
        apb(1'b1, `OFS_FEATURE, 32'hcc);
        cmd(`OP_SET_FEAT, 32'h40);
        srst();
        rd_chk(`OFS_MULTI, 32'h0);
        $display("test multi done");
        apb(1'b1, `OFS_CTRL, 32'h1e);
        cmd(`OP_SERVICE, 32'h40);
        rd_chk(`OFS_CTRL, 32'h0e);
        apb(1'b1, `OFS_CTRL, 32'h06);
        $display("test service done");
        apb(1'b1, `OFS_SECCNT, 32'h25);
        cmd(`OP_STANDBY_A, 32'h40);
        rd_chk(`OFS_POWER, 32'h495);
        apb(1'b1, `OFS_SECCNT, 32'h03);
        cmd(`OP_STANDBY_A, 32'h40);
        rd_chk(`OFS_POWER, 32'h40d);
        srst();
        repeat (40) @(posedge pclk);
        rd_chk(`OFS_POWER, 32'h40d);
        apb(1'b1, `OFS_SECCNT, 32'h0);
        cmd(`OP_STANDBY_B, 32'h40);
        rd_chk(`OFS_POWER, 32'h001);
        apb(1'b1, `OFS_SECCNT, 32'h05);
        cmd(`OP_INSTANT_A, 32'h40);
        rd_chk(`OFS_POWER, 32'h001);
        cmd(`OP_INSTANT_B, 32'h40);
        rd_chk(`OFS_POWER, 32'h001);
        $display("test standby done");
        apb(1'b1, `OFS_CTRL, 32'h04);
        foreach (ops[i]) cmd(ops[i], 32'h41);
        rd_chk(`OFS_ERROR, 32'h04);
        chk(pst[1], 1'b0);
        apb(1'b1, `OFS_CTRL, 32'h06);
        $display("test no power management done");
        apb(1'b1, `OFS_SECCNT, 32'h10);
        cmd(`OP_SET_MULTI, 32'h40);
        cmd(`OP_SLEEP_A, 32'h40);
        chk(pst, PWR_SLEEP);
        apb(1'b0, `OFS_MULTI, 32'h0);
        chk(err, 1'b1);
        srst();
        chk(pst, PWR_ACTIVE);
        cmd(`OP_SET_MULTI, 32'h40);
        apb(1'b1, `OFS_CMD, 32'he6);
        wait_irq();
        repeat (TO - 10) @(negedge pclk);
        chk(pst[1], 1'b0);
        repeat (20) @(negedge pclk);
        chk({irq, pst}, {1'b0, PWR_SLEEP});
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(pst, PWR_ACTIVE);
        rd_chk(`OFS_MULTI, 32'h0);
        $display("test sleep done");
        apb(1'b1, `OFS_CMD, 32'ha1);
        repeat (12) @(posedge pclk);
        rd_chk(`OFS_STATUS, 32'h48);
        for (int i = 0; i < 256; i++)
            rd_chk(`OFS_IDENT, i == 47 ? 32'h10 : 32'h0);
        wait_irq();
        rd_chk(`OFS_STATUS, 32'h40);
        $display("test identify done");
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
